// >>> hw/cttw_pkg.sv
package cttw_pkg;
  // Opcodes handled by this execution block.
  localparam logic [7:0] OP_SOFTWARE_TRAP = 8'h83;
  localparam logic [7:0] OP_ACC_TO_FLAGS = 8'h84;
  localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h85;
  localparam logic [7:0] OP_INDEX_PAIR_TO_STACK = 8'h94;
  localparam logic [7:0] OP_STACK_TO_INDEX_PAIR = 8'h95;
  localparam logic [7:0] OP_ACC_TO_INDEX_LOW = 8'h97;
  localparam logic [7:0] OP_INDEX_LOW_TO_ACC = 8'h9f;
  localparam logic [7:0] OP_WAIT_FOR_IRQ = 8'h8f;
  localparam logic [7:0] OP_STACK_PREFIX = 8'h9e;
  localparam logic [7:0] OP_TEST_DIRECT = 8'h3d;
  localparam logic [7:0] OP_TEST_ACC = 8'h4d;
  localparam logic [7:0] OP_TEST_INDEX_LOW = 8'h5d;
  localparam logic [7:0] OP_TEST_BYTE_OFFSET = 8'h6d;
  localparam logic [7:0] OP_TEST_NO_OFFSET = 8'h7d;
  localparam logic [7:0] OP_LOAD_FULL_ADDRESS = 8'hc6;
  localparam logic [7:0] OP_LOAD_WIDE_OFFSET = 8'hd6;
  // Condition flag bit positions.
  localparam int FLG_V = 7;
  localparam int FLG_H = 4;
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLAGS_FIXED_ONES = 8'h60;
  // Values after reset.
  localparam logic [7:0] FLAGS_RST = 8'h68;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h00ff;
  localparam logic [15:0] INDEX_RST = 16'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  // Trap vector locations.
  localparam logic [15:0] TRAP_VEC_HIGH = 16'hfffc;
  localparam logic [15:0] TRAP_VEC_LOW = 16'hfffd;
  // Cycle counter and cycle figures.
  localparam int STEP_W = 4;
  localparam logic [STEP_W-1:0] STEP_FIRST = 4'h1;
  localparam logic [STEP_W-1:0] TRAP_CYCLES = 4'h9;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01
  } cttw_state_t;
endpackage : cttw_pkg

// >>> hw/cttw_core.sv
`timescale 1ns/1ps
// What this block does
// - Software trap pushes PC low, PC high, X, A, flags, then loads vector.
// - Software trap sets the interrupt mask after stacking; other flags stay.
// - Test compares A, X or memory with zero; sets N, Z, clears V.
// - Test modes direct, A, X, byte offset, no offset, stack: 3,1,1,3,2,4 cycles.
// - Wait clears interrupt mask and halts core clocking until an interrupt.
// - Wide indexed offset comes high byte first, then low, added to H:X.
// - Full address follows the opcode high byte first, then low byte.
module cttw_core (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_MEM_RDATA,
  input wire logic I_IRQ,
  output logic [15:0] O_MEM_ADDR,
  output logic O_MEM_RD,
  output logic O_MEM_WR,
  output logic [7:0] O_MEM_WDATA,
  output logic O_CORE_CLK_EN,
  output logic O_INSN_DONE,
  output logic [7:0] O_ACC,
  output logic [15:0] O_INDEX,
  output logic [15:0] O_SP,
  output logic [15:0] O_PC,
  output logic [7:0] O_FLAGS
);
  import cttw_pkg::*;

  cttw_pkg::cttw_state_t st_r, st_nxt;
  logic [15:0] pc_r, pc_nxt, x_r, x_nxt, sp_r, sp_nxt, tmp_r, tmp_nxt, addr_r, addr_nxt;
  logic [7:0] acc_r, acc_nxt, flg_r, flg_nxt, op_r, op_nxt, wd_r, wd_nxt, cur_op, tst_val;
  logic [STEP_W-1:0] step_r, step_nxt, s;
  logic pre_r, pre_nxt, rd_r, rd_nxt, wr_r, wr_nxt, done_r, done_nxt, clken_r, clken_nxt;
  logic fetch_now, fin, halt, tst_fire;

  // Flags after a compare with zero: N and Z follow the value, V is cleared.
  function automatic logic [7:0] zero_test_flags(input logic [7:0] f, input logic [7:0] v);
    logic [7:0] r;
    r = f;
    r[FLG_N] = v[7];
    r[FLG_Z] = (v == 8'h00);
    r[FLG_V] = 1'b0;
    return r;
  endfunction : zero_test_flags

  // The opcode byte is on the read data in the first cycle, or the second after a prefix.
  assign fetch_now = (st_r == ST_RUN) && ((step_r == STEP_FIRST) || (pre_r && step_r == 4'h2));
  assign cur_op = fetch_now ? I_MEM_RDATA : op_r;
  // Sequence index counted from the real opcode, so prefixed forms share steps.
  assign s = pre_r ? 4'(step_r - 4'h1) : step_r;

  // Next-state logic: the bus request for the following cycle is decided here,
  // so every bus output leaves a flip-flop and the memory sees it a full cycle.
  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    x_nxt = x_r;
    sp_nxt = sp_r;
    acc_nxt = acc_r;
    flg_nxt = flg_r;
    op_nxt = op_r;
    pre_nxt = pre_r;
    tmp_nxt = tmp_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    done_nxt = 1'b0;
    clken_nxt = clken_r;
    step_nxt = 4'(step_r + 4'h1);
    fin = 1'b0;
    halt = 1'b0;
    tst_fire = 1'b0;
    tst_val = 8'h00;
    case (st_r)
      ST_WAIT: begin
        step_nxt = step_r;
        if (I_IRQ) begin
          st_nxt = ST_RUN;
          clken_nxt = 1'b1;
          step_nxt = STEP_FIRST;
          rd_nxt = 1'b1;
          addr_nxt = pc_r;
        end
      end
      ST_RUN: begin
        if (fetch_now) begin
          op_nxt = I_MEM_RDATA;
          pc_nxt = 16'(pc_r + 16'h0001);
        end
        case (cur_op)
          OP_STACK_PREFIX: begin
            if (!pre_r) begin
              pre_nxt = 1'b1;
              rd_nxt = 1'b1;
              addr_nxt = pc_nxt;
            end else begin
              fin = 1'b1;
            end
          end
          OP_SOFTWARE_TRAP: begin
            if (pre_r) begin
              fin = 1'b1;
            end else if (s >= 4'h2 && s <= 4'h6) begin
              wr_nxt = 1'b1;
              addr_nxt = sp_r;
              sp_nxt = 16'(sp_r - 16'h0001);
              case (s)
                4'h2: wd_nxt = pc_r[7:0];
                4'h3: wd_nxt = pc_r[15:8];
                4'h4: wd_nxt = x_r[7:0];
                4'h5: wd_nxt = acc_r;
                default: wd_nxt = flg_r;
              endcase
            end else if (s == 4'h7) begin
              flg_nxt[FLG_I] = 1'b1;
              rd_nxt = 1'b1;
              addr_nxt = TRAP_VEC_HIGH;
            end else if (s == 4'h8) begin
              tmp_nxt = {I_MEM_RDATA, 8'h00};
              rd_nxt = 1'b1;
              addr_nxt = TRAP_VEC_LOW;
            end else if (s == TRAP_CYCLES) begin
              pc_nxt = {tmp_r[15:8], I_MEM_RDATA};
              fin = 1'b1;
            end
          end
          OP_ACC_TO_FLAGS: begin
            if (s == 4'h2 || pre_r) begin
              if (!pre_r) flg_nxt = acc_r | FLAGS_FIXED_ONES;
              fin = 1'b1;
            end
          end
          OP_STACK_TO_INDEX_PAIR: begin
            if (s == 4'h2 || pre_r) begin
              if (!pre_r) x_nxt = 16'(sp_r + 16'h0001);
              fin = 1'b1;
            end
          end
          OP_INDEX_PAIR_TO_STACK: begin
            if (s == 4'h2 || pre_r) begin
              if (!pre_r) sp_nxt = 16'(x_r - 16'h0001);
              fin = 1'b1;
            end
          end
          OP_FLAGS_TO_ACC: begin
            if (!pre_r) acc_nxt = flg_r;
            fin = 1'b1;
          end
          OP_ACC_TO_INDEX_LOW: begin
            if (!pre_r) x_nxt[7:0] = acc_r;
            fin = 1'b1;
          end
          OP_INDEX_LOW_TO_ACC: begin
            if (!pre_r) acc_nxt = x_r[7:0];
            fin = 1'b1;
          end
          OP_WAIT_FOR_IRQ: begin
            fin = 1'b1;
            if (!pre_r) begin
              flg_nxt[FLG_I] = 1'b0;
              halt = 1'b1;
              st_nxt = ST_WAIT;
              clken_nxt = 1'b0;
            end
          end
          OP_TEST_ACC, OP_TEST_INDEX_LOW: begin
            tst_val = (cur_op == OP_TEST_ACC) ? acc_r : x_r[7:0];
            tst_fire = !pre_r;
            fin = 1'b1;
          end
          OP_TEST_NO_OFFSET: begin
            if (pre_r) begin
              fin = 1'b1;
            end else if (s == STEP_FIRST) begin
              rd_nxt = 1'b1;
              addr_nxt = x_r;
            end else begin
              tst_val = I_MEM_RDATA;
              tst_fire = 1'b1;
              fin = 1'b1;
            end
          end
          OP_TEST_DIRECT, OP_TEST_BYTE_OFFSET: begin
            // direct, byte offset and stack offset forms.
            if (pre_r && cur_op == OP_TEST_DIRECT) begin
              fin = 1'b1;
            end else if (s == STEP_FIRST) begin
              rd_nxt = 1'b1;
              addr_nxt = pc_nxt;
            end else if (s == 4'h2) begin
              pc_nxt = 16'(pc_r + 16'h0001);
              rd_nxt = 1'b1;
              if (cur_op == OP_TEST_DIRECT) addr_nxt = {8'h00, I_MEM_RDATA};
              else if (pre_r) addr_nxt = 16'(sp_r + {8'h00, I_MEM_RDATA});
              else addr_nxt = 16'(x_r + {8'h00, I_MEM_RDATA});
            end else begin
              tst_val = I_MEM_RDATA;
              tst_fire = 1'b1;
              fin = 1'b1;
            end
          end
          OP_LOAD_FULL_ADDRESS, OP_LOAD_WIDE_OFFSET: begin
            if (pre_r) begin
              fin = 1'b1;
            end else if (s == STEP_FIRST) begin
              rd_nxt = 1'b1;
              addr_nxt = pc_nxt;
            end else if (s == 4'h2) begin
              tmp_nxt = {I_MEM_RDATA, 8'h00};
              pc_nxt = 16'(pc_r + 16'h0001);
              rd_nxt = 1'b1;
              addr_nxt = pc_nxt;
            end else if (s == 4'h3) begin
              pc_nxt = 16'(pc_r + 16'h0001);
              rd_nxt = 1'b1;
              if (cur_op == OP_LOAD_WIDE_OFFSET) addr_nxt = 16'(x_r + {tmp_r[15:8], I_MEM_RDATA});
              else addr_nxt = {tmp_r[15:8], I_MEM_RDATA};
            end else begin
              acc_nxt = I_MEM_RDATA;
              flg_nxt = zero_test_flags(flg_r, I_MEM_RDATA);
              fin = 1'b1;
            end
          end
          default: fin = 1'b1;
        endcase
        if (tst_fire) flg_nxt = zero_test_flags(flg_r, tst_val);
        if (fin) begin
          done_nxt = 1'b1;
          pre_nxt = 1'b0;
          if (!halt) begin
            step_nxt = STEP_FIRST;
            rd_nxt = 1'b1;
            addr_nxt = pc_nxt;
          end
        end
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  // Registers only; the first fetch after reset reads at the reset address.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_r <= ST_RUN;
      pc_r <= PC_RST;
      x_r <= INDEX_RST;
      sp_r <= SP_RST;
      acc_r <= ACC_RST;
      flg_r <= FLAGS_RST;
      op_r <= 8'h00;
      pre_r <= 1'b0;
      tmp_r <= 16'h0000;
      addr_r <= PC_RST;
      wd_r <= 8'h00;
      rd_r <= 1'b1;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      clken_r <= 1'b1;
      step_r <= STEP_FIRST;
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      x_r <= x_nxt;
      sp_r <= sp_nxt;
      acc_r <= acc_nxt;
      flg_r <= flg_nxt;
      op_r <= op_nxt;
      pre_r <= pre_nxt;
      tmp_r <= tmp_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      done_r <= done_nxt;
      clken_r <= clken_nxt;
      step_r <= step_nxt;
    end
  end

  // Outputs are the registers themselves.
  assign O_MEM_ADDR = addr_r;
  assign O_MEM_RD = rd_r;
  assign O_MEM_WR = wr_r;
  assign O_MEM_WDATA = wd_r;
  assign O_CORE_CLK_EN = clken_r;
  assign O_INSN_DONE = done_r;
  assign O_ACC = acc_r;
  assign O_INDEX = x_r;
  assign O_SP = sp_r;
  assign O_PC = pc_r;
  assign O_FLAGS = flg_r;

  // Checks on the sequences above.
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic plain_fetch;
  assign plain_fetch = fetch_now && !pre_r;

  AST_TRAP_LENGTH: assert property (
    plain_fetch && I_MEM_RDATA == OP_SOFTWARE_TRAP |=> !O_INSN_DONE [*8] ##1 O_INSN_DONE)
    else $error("software trap did not take nine cycles");
  AST_TRAP_BUS: assert property (
    plain_fetch && I_MEM_RDATA == OP_SOFTWARE_TRAP |-> ##2 O_MEM_WR [*5]
    ##1 (O_MEM_RD && O_MEM_ADDR == TRAP_VEC_HIGH) ##1 (O_MEM_RD && O_MEM_ADDR == TRAP_VEC_LOW))
    else $error("software trap bus order wrong");
  AST_TRAP_MASK: assert property (
    plain_fetch && I_MEM_RDATA == OP_SOFTWARE_TRAP |-> ##9
    (O_FLAGS[FLG_I] && {O_FLAGS[7:4], O_FLAGS[2:0]} == $past({O_FLAGS[7:4], O_FLAGS[2:0]}, 9)))
    else $error("software trap flags wrong");
  AST_TEST_FLAGS: assert property (
    tst_fire |=> !O_FLAGS[FLG_V] && O_FLAGS[FLG_N] == $past(tst_val[7])
    && O_FLAGS[FLG_Z] == ($past(tst_val) == 8'h00) && O_FLAGS[FLG_I] == $past(O_FLAGS[FLG_I])
    && O_FLAGS[FLG_C] == $past(O_FLAGS[FLG_C]) && O_FLAGS[FLG_H] == $past(O_FLAGS[FLG_H]))
    else $error("test flags wrong");
  AST_TEST_DIRECT_LEN: assert property (
    plain_fetch && I_MEM_RDATA == OP_TEST_DIRECT |=> !O_INSN_DONE [*2] ##1 O_INSN_DONE)
    else $error("direct test length wrong");
  AST_TEST_ACC_LEN: assert property (
    plain_fetch && I_MEM_RDATA == OP_TEST_ACC |=> O_INSN_DONE && O_ACC == $past(O_ACC))
    else $error("accumulator test length wrong");
  AST_WAIT_HALT: assert property (
    plain_fetch && I_MEM_RDATA == OP_WAIT_FOR_IRQ && !I_IRQ
    |=> !O_CORE_CLK_EN && !O_FLAGS[FLG_I] && !O_MEM_RD)
    else $error("wait did not halt");
  AST_WIDE_OFFSET: assert property (
    plain_fetch && I_MEM_RDATA == OP_LOAD_WIDE_OFFSET |-> ##3
    O_MEM_ADDR == 16'({$past(I_MEM_RDATA, 2), $past(I_MEM_RDATA, 1)} + O_INDEX))
    else $error("wide offset order wrong");
  AST_FULL_ADDRESS: assert property (
    plain_fetch && I_MEM_RDATA == OP_LOAD_FULL_ADDRESS |-> ##3
    O_MEM_ADDR == {$past(I_MEM_RDATA, 2), $past(I_MEM_RDATA, 1)})
    else $error("full address order wrong");
  AST_STACK_TO_INDEX: assert property (
    plain_fetch && I_MEM_RDATA == OP_STACK_TO_INDEX_PAIR |-> ##2
    O_INDEX == 16'($past(O_SP, 2) + 16'h0001) && O_FLAGS == $past(O_FLAGS, 2))
    else $error("stack to index transfer wrong");
  COV_TRAP: cover property (plain_fetch && I_MEM_RDATA == OP_SOFTWARE_TRAP ##9 O_INSN_DONE);
  COV_WAIT_EXIT: cover property (st_r == ST_WAIT && I_IRQ);
  COV_STACK_TEST: cover property (tst_fire && pre_r);
  COV_FULL_ADDRESS: cover property (plain_fetch && I_MEM_RDATA == OP_LOAD_FULL_ADDRESS);
endmodule : cttw_core

// >>> dv/cttw_mem_model.sv
`timescale 1ns/1ps
// Zero-wait memory on the far side of the core's bus, holding program, data and stack.
module cttw_mem_model (
  input wire logic i_clk,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;
  // Writes land at the closing edge of the strobe cycle; the last read byte is kept.
  // A plain always is used because the bench also preloads this array at time zero.
  always @(posedge i_clk) begin
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_rd) begin
      last_r <= mem[i_addr];
    end
  end
  // bytes by address
  // An idle bus shows the inverse of the last byte, so a read outside a strobe cannot pass by luck.
  assign o_rdata = i_rd ? mem[i_addr] : ~last_r;
endmodule : cttw_mem_model

// >>> dv/cttw_core_tb.sv
`timescale 1ns/1ps
// Runs one fixed program through the core and compares the state after every instruction.
module cttw_core_tb;
  import cttw_pkg::*;
  typedef struct {
    int cyc;
    logic [7:0] acc;
    logic [7:0] flg;
    logic [15:0] idx;
    logic [15:0] sp;
    logic [15:0] pc;
  } cttw_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic irq = 1'b0;
  logic [7:0] mem_rdata;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic clk_en;
  logic done;
  logic [7:0] acc;
  logic [15:0] idx;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [7:0] flg;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  // Program at 0000: loads, transfers, every test mode, wide and full operands, trap.
  logic [7:0] prog [0:23] = '{8'hc6, 8'h02, 8'h04, 8'h84, 8'h97, 8'h4d, 8'h85, 8'h95,
    8'h3d, 8'h80, 8'h7d, 8'h5d, 8'h9f, 8'h6d, 8'hff, 8'h9e, 8'h6d, 8'h02, 8'hd6, 8'h01,
    8'h02, 8'h97, 8'h94, 8'h83};
  // Cycles, then A, flags, H:X, SP and PC expected once each instruction is done.
  cttw_row_t rows [0:16] = '{
    '{4, 8'h93, 8'h6c, 16'h0000, 16'h00ff, 16'h0003},
    '{2, 8'h93, 8'hf3, 16'h0000, 16'h00ff, 16'h0004},
    '{1, 8'h93, 8'hf3, 16'h0093, 16'h00ff, 16'h0005},
    '{1, 8'h93, 8'h75, 16'h0093, 16'h00ff, 16'h0006},
    '{1, 8'h75, 8'h75, 16'h0093, 16'h00ff, 16'h0007},
    '{2, 8'h75, 8'h75, 16'h0100, 16'h00ff, 16'h0008},
    '{3, 8'h75, 8'h73, 16'h0100, 16'h00ff, 16'h000a},
    '{2, 8'h75, 8'h75, 16'h0100, 16'h00ff, 16'h000b},
    '{1, 8'h75, 8'h73, 16'h0100, 16'h00ff, 16'h000c},
    '{1, 8'h00, 8'h73, 16'h0100, 16'h00ff, 16'h000d},
    '{3, 8'h00, 8'h75, 16'h0100, 16'h00ff, 16'h000f},
    '{4, 8'h00, 8'h73, 16'h0100, 16'h00ff, 16'h0012},
    '{4, 8'h40, 8'h71, 16'h0100, 16'h00ff, 16'h0015},
    '{1, 8'h40, 8'h71, 16'h0140, 16'h00ff, 16'h0016},
    '{2, 8'h40, 8'h71, 16'h0140, 16'h013f, 16'h0017},
    '{9, 8'h40, 8'h79, 16'h0140, 16'h013a, 16'h0300},
    '{1, 8'h40, 8'h71, 16'h0140, 16'h013a, 16'h0301}};
  // Bytes expected on the stack from 013f downwards after the trap.
  logic [7:0] stk [0:4] = '{8'h18, 8'h00, 8'h40, 8'h40, 8'h71};

  // Free-running clock of 100 ns.
  always #50 clk = ~clk;

  cttw_core dut (.I_CLK(clk), .I_RST(rst), .I_MEM_RDATA(mem_rdata), .I_IRQ(irq),
    .O_MEM_ADDR(mem_addr), .O_MEM_RD(mem_rd), .O_MEM_WR(mem_wr), .O_MEM_WDATA(mem_wdata),
    .O_CORE_CLK_EN(clk_en), .O_INSN_DONE(done), .O_ACC(acc), .O_INDEX(idx), .O_SP(sp),
    .O_PC(pc), .O_FLAGS(flg));

  cttw_mem_model u_mem (.i_clk(clk), .i_addr(mem_addr), .i_rd(mem_rd), .i_wr(mem_wr),
    .i_wdata(mem_wdata), .o_rdata(mem_rdata));

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // The run needs under 100 cycles; a hang is cut off well beyond that.
  initial begin
    #50000;
    miscompares++;
    stop_test();
  end

  // Main sequence: load memory, release reset, step through rows, then the awkward cases.
  initial begin
    for (int a = 0; a < 65536; a++) begin
      u_mem.mem[a] = 8'h00;
    end
    foreach (prog[i]) begin
      u_mem.mem[i] = prog[i];
    end
    // Operand bytes sit where a swapped byte order would not reach them.
    u_mem.mem[16'h0204] = 8'h93;
    u_mem.mem[16'h0080] = 8'h00;
    u_mem.mem[16'h0100] = 8'h93;
    u_mem.mem[16'h01ff] = 8'h80;
    u_mem.mem[16'h0202] = 8'h40;
    u_mem.mem[16'hfffc] = 8'h03;
    u_mem.mem[16'hfffd] = 8'h00;
    u_mem.mem[16'h0300] = 8'h8f;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    foreach (rows[r]) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (done !== 1'b1 && n < 20);
      check("cycles", 16'(n), 16'(rows[r].cyc));
      check("acc", {8'h00, acc}, {8'h00, rows[r].acc});
      check("flags", {8'h00, flg}, {8'h00, rows[r].flg});
      check("index", idx, rows[r].idx);
      check("stack pointer", sp, rows[r].sp);
      check("pc", pc, rows[r].pc);
    end
    foreach (stk[i]) begin
      check("stack byte", {8'h00, u_mem.mem[16'h013f - 16'(i)]}, {8'h00, stk[i]});
    end
    repeat (4) begin
      check("clock enable", {15'h0000, clk_en}, 16'h0000);
      check("strobes", {14'h0000, mem_rd, mem_wr}, 16'h0000);
      @(negedge clk);
    end
    @(posedge clk);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    @(negedge clk);
    check("clock enable", {15'h0000, clk_en}, 16'h0001);
    check("fetch", {mem_rd, mem_addr[14:0]}, 16'h8301);
    // A second reset in mid-run restores the reset state.
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("reset pc", pc, PC_RST);
    check("reset sp", sp, SP_RST);
    check("reset flags", {8'h00, flg}, {8'h00, FLAGS_RST});
    check("reset acc", {acc, idx[7:0]}, 16'h0000);
    check("reset index", idx, INDEX_RST);
    check("reset bus", {12'h000, mem_rd, mem_wr, done, clk_en}, 16'h0009);
    check("reset address", mem_addr, PC_RST);
    @(posedge clk);
    rst <= 1'b0;
    // The first cycle after release fetches at the reset address, the next takes the operand.
    @(negedge clk);
    check("first fetch", {mem_rd, mem_addr[14:0]}, 16'h8000);
    check("first done", {15'h0000, done}, 16'h0000);
    @(negedge clk);
    check("operand fetch", {mem_rd, mem_addr[14:0]}, 16'h8001);
    check("pc after fetch", pc, 16'h0001);
    stop_test();
  end
endmodule : cttw_core_tb
